// ---- hdl/uart_rx_parity_baud_regs.vh ----
// Register map, field layout and constants of the serial channel core
`ifndef UART_RX_PARITY_BAUD_REGS_VH
`define UART_RX_PARITY_BAUD_REGS_VH

// Register addresses
`define ADDR_MAIN_CONTROL 4'h0
`define ADDR_BASE_CLOCK_SELECT 4'h1
`define ADDR_DIVISOR 4'h2
`define ADDR_RECEIVE_STATUS 4'h3
`define ADDR_RX_DATA 4'h4
`define ADDR_TX_DATA 4'h5

// Main control fields
`define CTL_POWER_BIT 7
`define CTL_TX_ENABLE_BIT 6
`define CTL_RX_ENABLE_BIT 5
`define CTL_PARITY_HI_BIT 3
`define CTL_PARITY_LO_BIT 2

// Receive status fields
`define STS_PARITY_ERR_BIT 2
`define STS_FRAMING_ERR_BIT 1
`define STS_OVERRUN_ERR_BIT 0
`define STS_TX_BUSY_BIT 7

// Reset values
`define MAIN_CONTROL_RESET 8'h00
`define BASE_CLOCK_SELECT_RESET 8'h00
`define DIVISOR_RESET 8'hFF
`define RX_DATA_RESET 8'hFF

// Parity modes
`define PARITY_NONE 2'h0
`define PARITY_ZERO 2'h1
`define PARITY_ODD 2'h2
`define PARITY_EVEN 2'h3

// Base clock select codes
`define CLKSEL_MAX_DIV 4'hA
`define CLKSEL_EXTERNAL 4'hB

// Divisor limits and counts
`define DIVISOR_MIN 8'h04
`define DATA_BITS 4'h8
`define PRESCALE_WIDTH 10

`endif

// ---- hdl/uart_rx_parity_baud.v ----
// Serial channel core: parity, receive errors, noise filter, baud rate generator
// Behaviour
// - Parity mismatch sets the parity error flag
// - Low stop bit sets the framing error flag
// - Unread buffer on completion: overrun, frame dropped
// - Even parity transmit makes ones count even
// - Even parity receive errors on odd count
// - Odd parity transmit makes ones count odd
// - Odd parity receive errors on even count
// - Zero parity transmit always sends zero
// - Zero parity receive skips the check
// - No parity: no bit, no error
// - Filter changes after two equal samples
// - Receive logic sees line three clocks late
// - Separate 8-bit transmit and receive dividers
// - Dividers clocked only while power bit set
// - Divider ratio comes from divisor register
// - Select code picks prescaler tap or external
// - Base clock select resets to zero
// - Base clock select read and written whole
// - Any error sets flag and raises completion
// - Bit rate is base clock over 2k
//
// Added by the designer: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "uart_rx_parity_baud_regs.vh"

module uart_rx_parity_baud
(
  input wire sys_clk,
  input wire rst,
  input wire [3:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWrite,
  input wire regRead,
  output reg [7:0] regRdData,
  input wire serial_rx_pin,
  input wire ext_baud_clock_pin,
  output reg serialTxPin,
  output reg rx_complete_irq,
  output reg txEnableIrq
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Ones-count parity of a data byte
  function parityOf;
    input [7:0] d;
    begin
      parityOf = ^d;
    end
  endfunction

  // Parity bit sent for a given mode
  function txParityBit;
    input [1:0] mode;
    input [7:0] d;
    begin
      if (mode == `PARITY_EVEN)
        txParityBit = parityOf(d);
      else if (mode == `PARITY_ODD)
        txParityBit = ~parityOf(d);
      else
        txParityBit = 1'b0;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  reg [7:0] main_control_reg; // Power, enables, parity select
  reg [7:0] base_clock_select; // Base clock code
  reg [7:0] divisor_reg; // Divisor k
  reg [2:0] errFlags_reg; // Parity, framing, overrun
  reg [7:0] rxData_reg; // Receive buffer
  reg rxFull_reg; // Buffer holds unread byte
  reg [7:0] txData_reg; // Transmit buffer
  reg txPending_reg; // Transmit buffer waits for shifter

  wire power = main_control_reg[`CTL_POWER_BIT];
  wire txEnable = main_control_reg[`CTL_TX_ENABLE_BIT];
  wire rxEnable = main_control_reg[`CTL_RX_ENABLE_BIT];
  wire [1:0] parityMode = {main_control_reg[`CTL_PARITY_HI_BIT],
    main_control_reg[`CTL_PARITY_LO_BIT]};
  wire [3:0] clkSel = base_clock_select[3:0];

  ////////////////////////////////////////////////////////////////////////////
  // Base clock: prescaler taps and external pin

  reg [`PRESCALE_WIDTH-1:0] prescale_reg; // Free prescaler
  reg [1:0] extSync_reg; // External clock synchroniser
  reg extPrev_reg; // Last synchronised external level
  reg baseTick; // One-cycle base clock enable

  // Prescaler runs only with power on
  always @(posedge sys_clk)
  begin
    if (rst || !power)
    begin
      prescale_reg <= {`PRESCALE_WIDTH{1'b0}};
      extSync_reg <= 2'b00;
      extPrev_reg <= 1'b0;
    end
    else
    begin
      prescale_reg <= prescale_reg + 1'b1;
      extSync_reg <= {extSync_reg[0], ext_baud_clock_pin};
      extPrev_reg <= extSync_reg[1];
    end
  end

  // Tap select: fxx/2^m, or external rising edge
  always @*
  begin
    baseTick = 1'b0;
    if (!power)
      baseTick = 1'b0;
    else if (clkSel == 4'h0)
      baseTick = 1'b1;
    else if (clkSel <= `CLKSEL_MAX_DIV)
      baseTick = &prescale_reg[clkSel - 4'h1 -: 1] &&
        ((prescale_reg & ((10'h001 << clkSel) - 10'h001)) ==
        ((10'h001 << clkSel) - 10'h001));
    else if (clkSel == `CLKSEL_EXTERNAL)
      baseTick = extSync_reg[1] && !extPrev_reg;
    else
      baseTick = 1'b0; // Prohibited codes stop the clock
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive noise filter: two sampling stages then match detector

  reg [1:0] rxStage_reg; // A and B sampling stages
  reg rxFiltered_reg; // Match detector output, third stage

  // Sample pin on base clock; switch after two equal samples
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      rxStage_reg <= 2'b11;
      rxFiltered_reg <= 1'b1;
    end
    else if (baseTick)
    begin
      rxStage_reg <= {rxStage_reg[0], serial_rx_pin};
      if (rxStage_reg[1] == rxStage_reg[0])
        rxFiltered_reg <= rxStage_reg[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receiver

  localparam RX_IDLE = 2'b00;
  localparam RX_START = 2'b01;
  localparam RX_BITS = 2'b10;
  localparam RX_STOP = 2'b11;

  reg [1:0] rxState_reg; // Receive state
  reg [7:0] rxDiv_reg; // Receive divider counter
  reg rxHalf_reg; // Second half of bit
  reg [3:0] rxCount_reg; // Bits taken
  reg [8:0] rxShift_reg; // Data plus parity
  reg rxPrevLine_reg; // For falling edge
  wire hasParity = (parityMode != `PARITY_NONE);
  wire [3:0] rxLen = hasParity ? `DATA_BITS + 4'h1 : `DATA_BITS;
  wire rxHalfTick = baseTick && (rxDiv_reg == divisor_reg - 8'h01);
  wire statusRead = regRead && regAddr == `ADDR_RECEIVE_STATUS;
  wire dataRead = regRead && regAddr == `ADDR_RX_DATA;
  reg rxDone; // Frame completes this cycle
  reg [2:0] rxErrSet; // Errors found this frame

  // Receive sequencing and divider
  always @(posedge sys_clk)
  begin
    if (rst || !power || !rxEnable)
    begin
      rxState_reg <= RX_IDLE;
      rxDiv_reg <= 8'h00;
      rxHalf_reg <= 1'b0;
      rxCount_reg <= 4'h0;
      rxShift_reg <= 9'h000;
      rxPrevLine_reg <= 1'b1;
    end
    else
    begin
      rxPrevLine_reg <= rxFiltered_reg;
      if (rxHalfTick)
      begin
        rxDiv_reg <= 8'h00;
        rxHalf_reg <= ~rxHalf_reg;
      end
      else if (baseTick)
        rxDiv_reg <= rxDiv_reg + 8'h01;
      case (rxState_reg)
        RX_IDLE:
        begin
          if (rxPrevLine_reg && !rxFiltered_reg)
          begin
            rxState_reg <= RX_START;
            rxDiv_reg <= 8'h00;
            rxHalf_reg <= 1'b0;
          end
        end
        RX_START:
        begin
          // Midpoint of start bit: confirm low
          if (rxHalfTick && !rxHalf_reg)
          begin
            if (rxFiltered_reg)
              rxState_reg <= RX_IDLE;
            else
            begin
              rxState_reg <= RX_BITS;
              rxCount_reg <= 4'h0;
            end
          end
        end
        RX_BITS:
        begin
          if (rxHalfTick && !rxHalf_reg)
          begin
            rxShift_reg <= {rxFiltered_reg, rxShift_reg[8:1]};
            rxCount_reg <= rxCount_reg + 4'h1;
            if (rxCount_reg == rxLen - 4'h1)
              rxState_reg <= RX_STOP;
          end
        end
        default:
        begin
          if (rxHalfTick && !rxHalf_reg)
            rxState_reg <= RX_IDLE;
        end
      endcase
    end
  end

  // Completion and error detection at stop bit midpoint
  always @*
  begin
    rxDone = power && rxEnable && rxState_reg == RX_STOP && rxHalfTick && !rxHalf_reg;
    rxErrSet = 3'b000;
    if (rxDone)
    begin
      if (parityMode == `PARITY_EVEN)
        rxErrSet[`STS_PARITY_ERR_BIT] = ^rxShift_reg;
      else if (parityMode == `PARITY_ODD)
        rxErrSet[`STS_PARITY_ERR_BIT] = ~^rxShift_reg;
      else
        rxErrSet[`STS_PARITY_ERR_BIT] = 1'b0;
      rxErrSet[`STS_FRAMING_ERR_BIT] = !rxFiltered_reg;
      rxErrSet[`STS_OVERRUN_ERR_BIT] = rxFull_reg && !dataRead;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmitter

  reg [3:0] txState_reg; // 0 idle, else bit position
  reg [10:0] txShift_reg; // Start, data, parity, stop
  reg [7:0] txDiv_reg; // Transmit divider counter
  reg txHalf_reg; // Second half of bit
  wire txBitTick = baseTick && (txDiv_reg == divisor_reg - 8'h01) && txHalf_reg;
  wire [3:0] txLen = hasParity ? 4'hB : 4'hA;

  // Transmit shifter with own divider
  always @(posedge sys_clk)
  begin
    if (rst || !power || !txEnable)
    begin
      txState_reg <= 4'h0;
      txShift_reg <= 11'h7FF;
      txDiv_reg <= 8'h00;
      txHalf_reg <= 1'b0;
      serialTxPin <= 1'b1;
    end
    else
    begin
      if (baseTick && txDiv_reg == divisor_reg - 8'h01)
      begin
        txDiv_reg <= 8'h00;
        txHalf_reg <= ~txHalf_reg;
      end
      else if (baseTick)
        txDiv_reg <= txDiv_reg + 8'h01;
      if (txState_reg == 4'h0 && txPending_reg)
      begin
        // Parity bit inserted only when a parity mode is set
        if (hasParity)
          txShift_reg <= {1'b1, txParityBit(parityMode, txData_reg), txData_reg, 1'b0};
        else
          txShift_reg <= {2'b11, txData_reg, 1'b0};
        txState_reg <= txLen;
        txDiv_reg <= 8'h00;
        txHalf_reg <= 1'b0;
      end
      else if (txState_reg != 4'h0 && txBitTick)
      begin
        serialTxPin <= txShift_reg[0];
        txShift_reg <= {1'b1, txShift_reg[10:1]};
        txState_reg <= txState_reg - 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register bus

  // Writes, buffer fills and flag updates
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      main_control_reg <= `MAIN_CONTROL_RESET;
      base_clock_select <= `BASE_CLOCK_SELECT_RESET;
      divisor_reg <= `DIVISOR_RESET;
      errFlags_reg <= 3'b000;
      rxData_reg <= `RX_DATA_RESET;
      rxFull_reg <= 1'b0;
      txData_reg <= 8'h00;
      txPending_reg <= 1'b0;
      rx_complete_irq <= 1'b0;
      txEnableIrq <= 1'b0;
    end
    else
    begin
      if (regWrite && regAddr == `ADDR_MAIN_CONTROL)
        main_control_reg <= regWrData;
      else if (regWrite && regAddr == `ADDR_BASE_CLOCK_SELECT)
        base_clock_select <= regWrData;
      else if (regWrite && regAddr == `ADDR_DIVISOR)
        divisor_reg <= (regWrData < `DIVISOR_MIN) ? `DIVISOR_MIN : regWrData;
      // Writing 0 clears a flag; a new error wins
      if (regWrite && regAddr == `ADDR_RECEIVE_STATUS)
        errFlags_reg <= (errFlags_reg & regWrData[2:0]) | rxErrSet;
      else
        errFlags_reg <= errFlags_reg | rxErrSet;
      // Buffer fill on any completion without overrun, even with a parity or framing error; overrun frame dropped
      if (rxDone && !rxErrSet[`STS_OVERRUN_ERR_BIT])
      begin
        rxData_reg <= hasParity ? rxShift_reg[7:0] : rxShift_reg[8:1];
        rxFull_reg <= 1'b1;
      end
      else if (dataRead)
        rxFull_reg <= 1'b0;
      rx_complete_irq <= rxDone;
      // Transmit buffer handover
      if (regWrite && regAddr == `ADDR_TX_DATA)
      begin
        txData_reg <= regWrData;
        txPending_reg <= 1'b1;
      end
      else if (txState_reg == 4'h0 && txPending_reg && power && txEnable)
        txPending_reg <= 1'b0;
      txEnableIrq <= txState_reg == 4'h0 && txPending_reg && power && txEnable;
    end
  end

  // Read data one cycle after the read strobe
  always @(posedge sys_clk)
  begin
    if (rst)
      regRdData <= 8'h00;
    else if (regRead && regAddr == `ADDR_MAIN_CONTROL)
      regRdData <= main_control_reg;
    else if (regRead && regAddr == `ADDR_BASE_CLOCK_SELECT)
      regRdData <= base_clock_select;
    else if (regRead && regAddr == `ADDR_DIVISOR)
      regRdData <= divisor_reg;
    else if (statusRead)
      regRdData <= {txState_reg != 4'h0, 4'h0, errFlags_reg};
    else if (dataRead)
      regRdData <= rxData_reg;
    else
      regRdData <= 8'h00; // Unmapped or idle
  end

endmodule // uart_rx_parity_baud

`default_nettype wire

// ---- dv/uart_rx_parity_baud_chk.sv ----
// Checker of the serial channel core, bound to its ports
`timescale 1ns/1ps
`default_nettype none
module uart_rx_parity_baud_chk
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regRdData,
  input wire logic serial_rx_pin,
  input wire logic ext_baud_clock_pin,
  input wire logic serialTxPin,
  input wire logic rx_complete_irq,
  input wire logic txEnableIrq
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  // Shadow of the power bit
  logic pwrOn_reg;
  // Set once the select register has been written
  logic selSet_reg;
  ////////////////////////////////////////////////////////////////////////
  // Track power bit and select writes
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      pwrOn_reg <= 1'b0;
      selSet_reg <= 1'b0;
    end
    else if (regWrite && regAddr == 4'h0)
      pwrOn_reg <= regWrData[7];
    else if (regWrite && regAddr == 4'h1)
      selSet_reg <= 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////
  // Read data only in the cycle after a read
  a_read_idle: assert property (!$past(regRead) |-> regRdData == 8'h00)
    else $error("read data outside read slot");
  a_unmapped_zero: assert property (regRead && regAddr > 4'h5 |=> regRdData == 8'h00)
    else $error("unmapped read not zero");
  a_sel_reset: assert property (regRead && regAddr == 4'h1 && !selSet_reg
    |=> regRdData == 8'h00) else $error("select reset value wrong");
  a_sel_whole: assert property (regWrite && regAddr == 4'h1 ##1 regRead && regAddr == 4'h1
    |=> regRdData == $past(regWrData, 2)) else $error("select readback wrong");
  a_div_floor: assert property (regWrite && regAddr == 4'h2 && regWrData < 8'h04
    ##1 regRead && regAddr == 4'h2 |=> regRdData == 8'h04) else $error("divisor floor wrong");
  a_rx_pulse: assert property (rx_complete_irq |=> !rx_complete_irq [*8])
    else $error("receive completion not a single pulse");
  a_tx_pulse: assert property (txEnableIrq |=> !txEnableIrq [*8])
    else $error("transmit enable not a single pulse");
  a_unpowered_quiet: assert property (!pwrOn_reg && !$past(pwrOn_reg)
    |-> !rx_complete_irq && !txEnableIrq) else $error("activity while unpowered");
endmodule // uart_rx_parity_baud_chk
bind uart_rx_parity_baud uart_rx_parity_baud_chk uart_rx_parity_baud_chk_i (.sys_clk, .rst,
  .regAddr, .regWrData, .regWrite, .regRead, .regRdData, .serial_rx_pin, .ext_baud_clock_pin,
  .serialTxPin, .rx_complete_irq, .txEnableIrq);
`default_nettype wire

// ---- dv/uart_remote_node.sv ----
// Remote serial node model on the receive and transmit lines
`timescale 1ns/1ps
`default_nettype none
module uart_remote_node
(
  input wire logic sysClk,
  input wire logic txLine,
  output logic rxLine
);
  // Line idles high between frames
  initial rxLine = 1'b1;
  // Hold one level for a number of clocks
  task automatic bitOut(input logic b, input int cyc);
    rxLine <= b;
    repeat (cyc) @(posedge sysClk);
  endtask
  // Start, data LSB first, optional parity, stop, then idle
  task automatic send(input logic [7:0] d, input logic hasPar, input logic p,
    input logic stopBit, input int cyc);
    @(posedge sysClk);
    bitOut(1'b0, cyc);
    for (int i = 0; i < 8; i++)
      bitOut(d[i], cyc);
    if (hasPar)
      bitOut(p, cyc);
    bitOut(stopBit, cyc);
    bitOut(1'b1, cyc);
  endtask
  // Short low pulse on an idle line
  task automatic glitch(input int cyc);
    @(posedge sysClk);
    bitOut(1'b0, cyc);
    rxLine <= 1'b1;
  endtask
  // Capture eight data bits and the bit after them at midpoints
  task automatic recv(input int cyc, output logic [8:0] b);
    @(negedge txLine);
    repeat (cyc / 2) @(posedge sysClk);
    for (int i = 0; i < 9; i++)
    begin
      repeat (cyc) @(posedge sysClk);
      b[i] = txLine;
    end
  endtask
endmodule // uart_remote_node
`default_nettype wire

// ---- dv/tb_uart_rx_parity_baud.sv ----
// Testbench of the serial channel core
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin errors++; \
  $display("[ERR] %s exp %h got %h", n, e, a); end end
module tb_uart_rx_parity_baud;
  logic sys_clk, rst, regWrite, regRead, serialTx, rxIrq, txIrq, rxLine, g, extClk;
  logic [3:0] regAddr;
  logic [7:0] regWrData, regRdData, q;
  logic [8:0] bits;
  int errors = 0;
  int compares = 0;
  uart_rx_parity_baud uart_rx_parity_baud_i (.sys_clk(sys_clk), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .serial_rx_pin(rxLine), .ext_baud_clock_pin(extClk), .serialTxPin(serialTx),
    .rx_complete_irq(rxIrq), .txEnableIrq(txIrq));
  uart_remote_node node_i (.sysClk(sys_clk), .txLine(serialTx), .rxLine(rxLine));
  ////////////////////////////////////////////////////////////////////////
  // Register bus cycles
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge sys_clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRead <= 1'b0;
    #1 d = regRdData;
  endtask
  // Write then read the same place with no gap
  task automatic wrRd(input logic [3:0] a, input logic [7:0] d, output logic [7:0] r);
    wr(a, d);
    regRead <= 1'b1;
    @(posedge sys_clk);
    regRead <= 1'b0;
    #1 r = regRdData;
  endtask
  // Bounded wait for the receive completion pulse
  task automatic waitIrq(output logic got);
    got = 1'b0;
    for (int i = 0; i < 300 && !got; i++)
    begin
      @(posedge sys_clk);
      #1 got = (rxIrq === 1'b1);
    end
  endtask
  // Power off, select clock, divisor 4, clear status, power on in mode m
  task automatic cfg(input logic [1:0] m, input logic [3:0] s);
    wr(4'h0, 8'h00);
    wr(4'h1, {4'h0, s});
    wr(4'h2, 8'h04);
    wr(4'h3, 8'h00);
    wr(4'h0, {4'hE, m, 2'b00});
    rd(4'h4, q);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic test_regs;
    rd(4'h1, q);
    `CHK("select reset", 8'h00, q)
    rd(4'h2, q);
    `CHK("divisor reset", 8'hFF, q)
    rd(4'hE, q);
    `CHK("unmapped read", 8'h00, q)
    wrRd(4'h1, 8'hA5, q);
    `CHK("select readback", 8'hA5, q)
    wrRd(4'h2, 8'h02, q);
    `CHK("divisor floor", 8'h04, q)
    $display("test_regs done");
  endtask
  task automatic test_tx_parity;
    logic [7:0] d;
    logic e;
    for (int m = 0; m < 4; m++)
      for (int j = 0; j < 2; j++)
      begin
        d = j ? 8'h03 : 8'h07;
        e = (m == 3) ? ^d : (m == 2) ? ~^d : (m == 1) ? 1'b0 : 1'b1;
        cfg(m[1:0], 4'h0);
        fork
          node_i.recv(8, bits);
          begin
            wr(4'h5, d);
            @(posedge sys_clk);
            #1 g = txIrq;
          end
        join
        `CHK("tx handover", 1'b1, g)
        `CHK("tx data", d, bits[7:0])
        `CHK("tx parity or stop", e, bits[8])
      end
    cfg(2'b00, 4'h1);
    fork
      node_i.recv(16, bits);
      wr(4'h5, 8'h3C);
    join
    `CHK("tx data halved clock", 8'h3C, bits[7:0])
    $display("test_tx_parity done");
  endtask
  // Base clock from the external pin, one tick every two clocks
  task automatic test_ext_clock;
    cfg(2'b00, 4'hB);
    fork
      node_i.recv(16, bits);
      wr(4'h5, 8'hC3);
      repeat (300) @(posedge sys_clk) extClk <= ~extClk;
    join
    `CHK("tx data external clock", 8'hC3, bits[7:0])
    `CHK("tx stop external clock", 1'b1, bits[8])
    $display("test_ext_clock done");
  endtask
  task automatic test_rx_parity;
    logic e;
    for (int m = 0; m < 4; m++)
      for (int p = 0; p < 2; p++)
      begin
        e = (m == 3) ? ~p[0] : (m == 2) ? p[0] : 1'b0;
        cfg(m[1:0], 4'h0);
        fork
          node_i.send(8'h07, m != 0, p[0], 1'b1, 8);
          waitIrq(g);
        join
        `CHK("rx irq", 1'b1, g)
        rd(4'h3, q);
        `CHK("parity error", e, q[2])
        rd(4'h4, q);
        `CHK("rx data", 8'h07, q)
      end
    $display("test_rx_parity done");
  endtask
  task automatic test_framing;
    cfg(2'b11, 4'h0);
    fork
      node_i.send(8'h5A, 1'b1, 1'b0, 1'b0, 8);
      waitIrq(g);
    join
    `CHK("irq on error", 1'b1, g)
    rd(4'h3, q);
    `CHK("framing error", 1'b1, q[1])
    `CHK("no parity error", 1'b0, q[2])
    $display("test_framing done");
  endtask
  task automatic test_overrun;
    cfg(2'b00, 4'h0);
    node_i.send(8'h91, 1'b0, 1'b0, 1'b1, 8);
    node_i.send(8'h22, 1'b0, 1'b0, 1'b1, 8);
    rd(4'h3, q);
    `CHK("overrun error", 1'b1, q[0])
    rd(4'h4, q);
    `CHK("first frame kept", 8'h91, q)
    $display("test_overrun done");
  endtask
  task automatic test_noise_power;
    cfg(2'b00, 4'h0);
    node_i.glitch(2);
    waitIrq(g);
    `CHK("glitch ignored", 1'b0, g)
    wr(4'h0, 8'h20);
    fork
      node_i.send(8'h55, 1'b0, 1'b0, 1'b1, 8);
      waitIrq(g);
    join
    `CHK("unpowered silent", 1'b0, g)
    $display("test_noise_power done");
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Report counts and verdict, then end the run
  task automatic stop_test;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Clock of 20 ns
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // Watchdog well beyond the expected run
  initial
  begin
    #400000;
    errors++;
    stop_test;
  end
  // Main sequence
  initial
  begin
    rst = 1'b1;
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 4'h0;
    regWrData = 8'h00;
    extClk = 1'b0;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    test_regs;
    test_tx_parity;
    test_ext_clock;
    test_rx_parity;
    test_framing;
    test_overrun;
    test_noise_power;
    stop_test;
  end
endmodule // tb_uart_rx_parity_baud
`default_nettype wire
